// ===== logic/lieb_defines.vh
// Constants for the local interrupt unit enable, base and reset block.
// Assumes inclusion by bare name from the design files.
`ifndef LIEB_DEFINES_VH
`define LIEB_DEFINES_VH
`define LIEB_BASE_MSR_ADDR   32'h0000001b
`define LIEB_BSP_BIT         8
`define LIEB_GEN_BIT         11
`define LIEB_BASE_LO         12
`define LIEB_BASE_HI         35
`define LIEB_BASE_RESET      24'h0fee00
`define LIEB_SVR_RESET       32'h000000ff
`define LIEB_SVR_EN_BIT      8
`define LIEB_SVR_WMASK       32'h000001ff
`define LIEB_DFR_RESET       32'hffffffff
`define LIEB_DFR_WMASK       32'hf0000000
`define LIEB_LVT_RESET       32'h00010000
`define LIEB_LVT_MASK_BIT    16
`define LIEB_LVT_COUNT       6
`define LIEB_PROCESSOR_IDENTIFICATION_INSTRUCTION_ID_LO     24
`define LIEB_FEAT_PRESENT    9
`define LIEB_OFF_ID          12'h020
`define LIEB_OFF_VER         12'h030
`define LIEB_OFF_TPR         12'h080
`define LIEB_OFF_LDR         12'h0d0
`define LIEB_OFF_DFR         12'h0e0
`define LIEB_OFF_SVR         12'h0f0
`define LIEB_OFF_ICR_LO      12'h300
`define LIEB_OFF_ICR_HI      12'h310
`define LIEB_OFF_LVT0        12'h320
`define LIEB_OFF_LVT_LAST    12'h370
`define LIEB_OFF_INIT_CNT    12'h380
`define LIEB_OFF_DIV_CFG     12'h3e0
`endif

// ===== logic/lieb_core.v
// Enable, base address, identity and reset state of a local interrupt unit.
// Assumes a core-side MSR port, a memory-window port and sampled ID pins.
`timescale 1ns/1ps
`include "lieb_defines.vh"

// Overview of operation
// - Global enable off hides unit, except stop-clock acceptance
// - Three-wire parts stay off until reset
// - Bus parts may re-enable without reset
// - Global disable returns power-up register state, except identifier and arbitration
// - Software enable bit toggles temporary disable
// - Bootstrap flag reflects strap after reset
// - Base field bits 35:12, 4K aligned
// - Reset base window at fee00000
// - Reserved MSR bits read zero
// - New base moves the register window
// - Identifier latched from pins at reset
// - Identification returns initial identifier always
// - Identifier width four or eight bits
// - Reset clears listed registers to zero
// - Destination format resets to all ones
// - Vector entries reset masked, else zero
// - Version untouched; arbitration copies identifier
// - Spurious register resets to 000000ff
// - Accept init, nmi; stop-clock except on three-wire APs; startup on APs
// - Disabled still handles special messages, holds bits
// - Disabled unit can still send messages
// - Disable waits for transfers; masks forced
// - Init reset keeps identifier and arbitration
module lieb_core #(
    parameter THREE_WIRE = 0,
    parameter ID_WIDTH   = 8,
    parameter VERSION    = 32'h00050010
) (
    clk,
    rstn,
    strap_bsp,
    strap_id,
    init_reset,
    msr_wr,
    msr_rd,
    msr_addr,
    msr_wdata,
    msr_rdata,
    mem_wr,
    mem_rd,
    mem_addr,
    mem_wdata,
    mem_rdata,
    mem_hit,
    msg_busy,
    msg_init,
    msg_nmi,
    msg_smi,
    msg_startup,
    stop_clock_signal,
    accept_init,
    accept_nmi,
    accept_smi,
    accept_startup,
    accept_stop_clock,
    ipi_send,
    fixed_accept,
    unit_present,
    unit_active,
    initial_id_out,
    lvt_mask_out,
    window_base
);
    input             clk;
    input             rstn;
    input             strap_bsp;
    input  [ID_WIDTH-1:0] strap_id;
    input             init_reset;
    input             msr_wr;
    input             msr_rd;
    input  [31:0]     msr_addr;
    input  [63:0]     msr_wdata;
    output [63:0]     msr_rdata;
    input             mem_wr;
    input             mem_rd;
    input  [35:0]     mem_addr;
    input  [31:0]     mem_wdata;
    output [31:0]     mem_rdata;
    output            mem_hit;
    input             msg_busy;
    input             msg_init;
    input             msg_nmi;
    input             msg_smi;
    input             msg_startup;
    input             stop_clock_signal;
    output            accept_init;
    output            accept_nmi;
    output            accept_smi;
    output            accept_startup;
    output            accept_stop_clock;
    output            ipi_send;
    output            fixed_accept;
    output            unit_present;
    output            unit_active;
    output [ID_WIDTH-1:0] initial_id_out;
    output [`LIEB_LVT_COUNT-1:0] lvt_mask_out;
    output [35:0]     window_base;

    reg  [63:0] msr_rdata;
    reg  [31:0] mem_rdata_reg;
    reg  [1:0]  rst_sync;
    reg  [1:0]  bsp_sync;
    reg  [ID_WIDTH-1:0] id_s1;
    reg  [ID_WIDTH-1:0] id_s2;
    reg         strap_done_reg;
    reg         bsp_reg;
    reg         gen_reg;
    reg         dead_reg;
    reg  [23:0] base_reg;
    reg  [ID_WIDTH-1:0] init_id_reg;
    reg  [ID_WIDTH-1:0] id_reg;
    reg  [ID_WIDTH-1:0] arb_reg;
    reg  [31:0] svr_reg;
    reg  [31:0] dfr_reg;
    reg  [7:0]  tpr_reg;
    reg  [31:0] ldr_reg;
    reg  [31:0] icr_lo_reg;
    reg  [31:0] icr_hi_reg;
    reg  [31:0] init_cnt_reg;
    reg  [31:0] div_cfg_reg;
    reg  [31:0] lvt_reg [0:`LIEB_LVT_COUNT-1];
    reg         sw_off_reg;
    reg         ipi_send_reg;
    wire        srst_n;
    wire        soft_clr;
    wire        sw_en;
    wire [11:0] off;
    wire [63:0] msr_full;

    // Single reset release point for all registers except the strap synchronizers
    always @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            rst_sync <= 2'h0;
        end else begin
            rst_sync <= {rst_sync[0], 1'h1};
        end
    end
    assign srst_n = rst_sync[1];

    always @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            bsp_sync <= 2'h0;
            id_s1    <= {ID_WIDTH{1'b0}};
            id_s2    <= {ID_WIDTH{1'b0}};
        end else begin
            bsp_sync <= {bsp_sync[0], strap_bsp};
            id_s1    <= strap_id;
            id_s2    <= id_s1;
        end
    end

    assign sw_en    = svr_reg[`LIEB_SVR_EN_BIT];
    // global disable or init reset clears programming
    assign soft_clr = init_reset | ~gen_reg;
    assign window_base = {base_reg, 12'h000};
    assign off      = mem_addr[11:0];
    assign mem_hit  = gen_reg & (mem_addr[35:12] == base_reg);

    // arbitration copies identifier on hard reset
    always @(posedge clk or negedge srst_n) begin
        if (!srst_n) begin
            strap_done_reg <= 1'h0;
            bsp_reg        <= 1'h0;
            init_id_reg    <= {ID_WIDTH{1'b0}};
            id_reg         <= {ID_WIDTH{1'b0}};
            arb_reg        <= {ID_WIDTH{1'b0}};
        end else if (!strap_done_reg) begin
            strap_done_reg <= 1'h1;
            bsp_reg        <= bsp_sync[1];
            init_id_reg    <= id_s2;
            id_reg         <= id_s2;
            arb_reg        <= id_s2;
        end else if (mem_wr && mem_hit && off == `LIEB_OFF_ID) begin
            // identifier field sits in the top bits
            id_reg <= mem_wdata[31:32-ID_WIDTH];
        end
    end

    always @(posedge clk or negedge srst_n) begin
        if (!srst_n) begin
            gen_reg  <= 1'h1;
            dead_reg <= 1'h0;
            base_reg <= `LIEB_BASE_RESET;
        end else if (msr_wr && msr_addr == `LIEB_BASE_MSR_ADDR) begin
            base_reg <= msr_wdata[`LIEB_BASE_HI:`LIEB_BASE_LO];
            if (!msr_wdata[`LIEB_GEN_BIT]) begin
                gen_reg  <= 1'h0;
                // Three-wire arbitration is lost once turned off
                dead_reg <= (THREE_WIRE != 0);
            end else if (!dead_reg) begin
                gen_reg <= 1'h1;
            end
        end
    end

    // reserved MSR bits read as zero
    assign msr_full = {28'h0000000, base_reg, gen_reg, 2'h0, bsp_reg, 8'h00};
    always @* begin
        msr_rdata = 64'h0;
        if (msr_rd && msr_addr == `LIEB_BASE_MSR_ADDR) begin
            msr_rdata = msr_full;
        end
    end

    always @(posedge clk or negedge srst_n) begin
        if (!srst_n) begin
            sw_off_reg <= 1'h1;
        end else if (sw_en && gen_reg) begin
            sw_off_reg <= 1'h0;
        end else if (!msg_busy) begin
            sw_off_reg <= 1'h1;
        end
    end

    always @(posedge clk or negedge srst_n) begin
        if (!srst_n) begin
            svr_reg      <= `LIEB_SVR_RESET;
            dfr_reg      <= `LIEB_DFR_RESET;
            tpr_reg      <= 8'h00;
            ldr_reg      <= 32'h00000000;
            icr_lo_reg   <= 32'h00000000;
            icr_hi_reg   <= 32'h00000000;
            init_cnt_reg <= 32'h00000000;
            div_cfg_reg  <= 32'h00000000;
            ipi_send_reg <= 1'h0;
        end else if (soft_clr) begin
            svr_reg      <= `LIEB_SVR_RESET;
            dfr_reg      <= `LIEB_DFR_RESET;
            tpr_reg      <= 8'h00;
            ldr_reg      <= 32'h00000000;
            icr_lo_reg   <= 32'h00000000;
            icr_hi_reg   <= 32'h00000000;
            init_cnt_reg <= 32'h00000000;
            div_cfg_reg  <= 32'h00000000;
            ipi_send_reg <= 1'h0;
        end else begin
            ipi_send_reg <= 1'h0;
            if (mem_wr && mem_hit) begin
                // software enable bit in bit 8
                if (off == `LIEB_OFF_SVR) begin
                    svr_reg <= (svr_reg & ~`LIEB_SVR_WMASK) |
                               (mem_wdata & `LIEB_SVR_WMASK);
                end else if (off == `LIEB_OFF_DFR) begin
                    dfr_reg <= (dfr_reg & ~`LIEB_DFR_WMASK) |
                               (mem_wdata & `LIEB_DFR_WMASK);
                end else if (off == `LIEB_OFF_TPR) begin
                    tpr_reg <= mem_wdata[7:0];
                end else if (off == `LIEB_OFF_LDR) begin
                    ldr_reg <= mem_wdata;
                end else if (off == `LIEB_OFF_ICR_HI) begin
                    icr_hi_reg <= mem_wdata;
                end else if (off == `LIEB_OFF_ICR_LO) begin
                    icr_lo_reg   <= mem_wdata;
                    ipi_send_reg <= 1'h1;
                end else if (off == `LIEB_OFF_INIT_CNT) begin
                    init_cnt_reg <= mem_wdata;
                end else if (off == `LIEB_OFF_DIV_CFG) begin
                    div_cfg_reg <= mem_wdata;
                end
            end
        end
    end

    genvar g;
    generate
        for (g = 0; g < `LIEB_LVT_COUNT; g = g + 1) begin : local_vector_table
            // entries masked on reset and when disabled
            always @(posedge clk or negedge srst_n) begin
                if (!srst_n) begin
                    lvt_reg[g] <= `LIEB_LVT_RESET;
                end else if (soft_clr) begin
                    lvt_reg[g] <= `LIEB_LVT_RESET;
                end else if (mem_wr && mem_hit &&
                             off == `LIEB_OFF_LVT0 + g * 12'h010) begin
                    lvt_reg[g] <= mem_wdata;
                    if (sw_off_reg) begin
                        lvt_reg[g][`LIEB_LVT_MASK_BIT] <= 1'h1;
                    end
                end else if (sw_off_reg) begin
                    lvt_reg[g][`LIEB_LVT_MASK_BIT] <= 1'h1;
                end
            end
            assign lvt_mask_out[g] = lvt_reg[g][`LIEB_LVT_MASK_BIT];
        end
    endgenerate

    // Read data registered one cycle after the request
    always @(posedge clk or negedge srst_n) begin
        if (!srst_n) begin
            mem_rdata_reg <= 32'h00000000;
        end else if (mem_rd && mem_hit) begin
            if (off == `LIEB_OFF_ID) begin
                mem_rdata_reg <= {id_reg, {(32-ID_WIDTH){1'b0}}};
            end else if (off == `LIEB_OFF_VER) begin
                mem_rdata_reg <= VERSION;
            end else if (off == `LIEB_OFF_SVR) begin
                mem_rdata_reg <= svr_reg;
            end else if (off == `LIEB_OFF_DFR) begin
                mem_rdata_reg <= dfr_reg;
            end else if (off == `LIEB_OFF_TPR) begin
                mem_rdata_reg <= {24'h000000, tpr_reg};
            end else if (off == `LIEB_OFF_LDR) begin
                mem_rdata_reg <= ldr_reg;
            end else if (off == `LIEB_OFF_ICR_LO) begin
                mem_rdata_reg <= icr_lo_reg;
            end else if (off == `LIEB_OFF_ICR_HI) begin
                mem_rdata_reg <= icr_hi_reg;
            end else if (off == `LIEB_OFF_INIT_CNT) begin
                mem_rdata_reg <= init_cnt_reg;
            end else if (off == `LIEB_OFF_DIV_CFG) begin
                mem_rdata_reg <= div_cfg_reg;
            end else if (off >= `LIEB_OFF_LVT0 &&
                         off <= `LIEB_OFF_LVT_LAST) begin
                mem_rdata_reg <= lvt_reg[off[6:4] - 3'h2];
            end else begin
                mem_rdata_reg <= 32'h00000000;
            end
        end else begin
            mem_rdata_reg <= 32'h00000000;
        end
    end
    assign mem_rdata = mem_rdata_reg;

    assign unit_present   = gen_reg;
    assign initial_id_out = init_id_reg;
    assign unit_active    = gen_reg & ~sw_off_reg;
    assign accept_init    = gen_reg & msg_init;
    assign accept_nmi     = gen_reg & msg_nmi;
    assign accept_smi     = gen_reg & msg_smi;
    assign accept_startup = gen_reg & msg_startup & ~bsp_reg;
    assign accept_stop_clock = stop_clock_signal &
                               (bsp_reg | (THREE_WIRE == 0));
    assign fixed_accept   = unit_active;
    assign ipi_send       = ipi_send_reg & gen_reg;
endmodule

// ===== bench/lieb_msg_partner.sv
// Message bus and strap pins seen by the interrupt unit.
// Assumes the bench pulses go for one cycle with a message kind.
`timescale 1ns/1ps
module lieb_msg_partner (
    input  wire       clk,
    input  wire       go,
    input  wire [2:0] kind,
    output reg        busy,
    output reg  [4:0] msg,
    output wire       bootstrap_processor_flag,
    output wire [7:0] id
);
    reg [1:0] cnt_reg = 2'h0;
    assign id  = 8'h5a;
    assign bootstrap_processor_flag = 1'b1;
    initial busy = 1'b0;
    initial msg = 5'h00;
    // Line held for the whole transfer
    always @(posedge clk) begin
        if (go) begin
            busy    <= 1'b1;
            msg     <= 5'h01 << kind;
            cnt_reg <= 2'h3;
        end else if (cnt_reg != 2'h0) begin
            cnt_reg <= cnt_reg - 2'h1;
            busy    <= (cnt_reg != 2'h1);
        end else begin
            msg <= 5'h00;
        end
    end
endmodule

// ===== bench/lieb_core_checker.sv
// Port-level checks on the interrupt unit enable and base block.
// Assumes binding onto lieb_core with its single core clock.
`timescale 1ns/1ps
module lieb_core_checker #(parameter ID_WIDTH = 8) (
    input wire        clk,
    input wire        rstn,
    input wire        msr_rd,
    input wire [31:0] msr_addr,
    input wire [63:0] msr_rdata,
    input wire        mem_wr,
    input wire        mem_rd,
    input wire [35:0] mem_addr,
    input wire        mem_hit,
    input wire [31:0] mem_rdata,
    input wire        msg_busy,
    input wire        msg_init,
    input wire        msg_smi,
    input wire        accept_init,
    input wire        accept_smi,
    input wire        ipi_send,
    input wire        unit_present,
    input wire        unit_active,
    input wire [5:0]  lvt_mask_out,
    input wire [35:0] window_base
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rstn);
    sequence s_msr;
        msr_rd && msr_addr == 32'h0000001b;
    endsequence
    sequence s_icr_wr;
        mem_wr && mem_hit && mem_addr[11:0] == 12'h300;
    endsequence
    sequence s_quiet;
        (unit_present && !unit_active && !msg_busy) [*2];
    endsequence
    property p_absent;
        !unit_present |-> !mem_hit && !unit_active;
    endproperty
    property p_flag;
        s_msr |-> msr_rdata[11] == unit_present;
    endproperty
    property p_rsvd;
        s_msr |-> msr_rdata[63:36] == 28'h0 && msr_rdata[10:9] == 2'h0
            && msr_rdata[7:0] == 8'h00;
    endproperty
    property p_win;
        s_msr |-> window_base == {msr_rdata[35:12], 12'h000};
    endproperty
    property p_ipi;
        s_icr_wr |=> ipi_send;
    endproperty
    property p_miss;
        !(mem_rd && mem_hit) |=> mem_rdata == 32'h0;
    endproperty
    property p_mask;
        s_quiet |-> lvt_mask_out == 6'h3f;
    endproperty
    property p_init;
        unit_present && msg_init |-> accept_init;
    endproperty
    property p_smi;
        unit_present && msg_smi |-> accept_smi;
    endproperty
    a_absent: assert property (p_absent) else $error("unit seen");
    a_flag: assert property (p_flag) else $error("enable flag");
    a_rsvd: assert property (p_rsvd) else $error("reserved set");
    a_win: assert property (p_win) else $error("window base");
    a_ipi: assert property (p_ipi) else $error("no send");
    a_miss: assert property (p_miss) else $error("stray data");
    a_mask: assert property (p_mask) else $error("mask clear");
    a_init: assert property (p_init) else $error("init lost");
    a_smi: assert property (p_smi) else $error("smi lost");
endmodule
bind lieb_core lieb_core_checker #(.ID_WIDTH(ID_WIDTH)) chk_inst (.clk,
    .rstn, .msr_rd, .msr_addr, .msr_rdata, .mem_wr, .mem_rd, .mem_addr,
    .mem_hit, .mem_rdata, .msg_busy, .msg_init, .msg_smi, .accept_init,
    .accept_smi, .ipi_send, .unit_present, .unit_active, .lvt_mask_out,
    .window_base);

// ===== bench/local_intc_enable_base_reset_tb_top.sv
// Directed bench for the interrupt unit enable, base and reset block.
// Assumes lieb_core with bus delivery and an 8-bit identifier.
`timescale 1ns/1ps
`include "lieb_defines.vh"
`define CHK(a, b) begin checks++; if ((a) !== (b)) begin n_mismatch++; \
    $display("CHECK FAILED t=%0t got=%h exp=%h", $time, a, b); end end
module local_intc_enable_base_reset_tb_top;
    reg clk = 0, rstn = 0, init_reset = 0, go = 0;
    reg msr_wr = 0, msr_rd = 0, mem_wr = 0, mem_rd = 0;
    reg [31:0] msr_addr = 0, mem_wdata = 0;
    reg [63:0] msr_wdata = 0;
    reg [35:0] mem_addr = 0;
    reg [2:0] kind = 0;
    reg [23:0] base = `LIEB_BASE_RESET;
    wire [63:0] msr_rdata;
    wire [31:0] mem_rdata;
    wire [35:0] window_base;
    wire [7:0] id, initial_id_out;
    wire [5:0] lvt_mask_out;
    wire [4:0] msg;
    wire mem_hit, bootstrap_processor_flag, busy, accept_init, accept_smi, ipi_send;
    wire unit_present, unit_active;
    wire accept_nmi, accept_startup, accept_stop_clock, fixed_accept;
    int checks = 0, n_mismatch = 0;
    reg [63:0] q;
    reg [31:0] d;
    lieb_msg_partner lieb_msg_partner_inst (.clk, .go, .kind, .busy,
        .msg, .bootstrap_processor_flag, .id);
    lieb_core lieb_core_inst (.clk, .rstn, .strap_bsp(bootstrap_processor_flag), .strap_id(id),
        .init_reset, .msr_wr, .msr_rd, .msr_addr, .msr_wdata, .msr_rdata,
        .mem_wr, .mem_rd, .mem_addr, .mem_wdata, .mem_rdata, .mem_hit,
        .msg_busy(busy), .msg_init(msg[0]), .msg_nmi(msg[1]),
        .msg_smi(msg[2]), .msg_startup(msg[3]),
        .stop_clock_signal(msg[4]), .accept_init, .accept_nmi,
        .accept_smi, .accept_startup, .accept_stop_clock, .ipi_send,
        .fixed_accept, .unit_present, .unit_active, .initial_id_out,
        .lvt_mask_out, .window_base);
    initial forever #4 clk = ~clk;
    task test_done;
        $display("checks=%0d mismatches=%0d", checks, n_mismatch);
        if (n_mismatch == 0 && checks > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask
    task msr_w(input [63:0] v);
        @(posedge clk) begin msr_wr <= 1; msr_addr <= 32'h1b; end
        msr_wdata <= v;
        @(posedge clk) msr_wr <= 0;
        #1;
    endtask
    task msr_r;
        @(posedge clk) begin msr_rd <= 1; msr_addr <= 32'h1b; end
        #1 q = msr_rdata;
        @(posedge clk) msr_rd <= 0;
    endtask
    task mw(input [11:0] o, input [31:0] v);
        @(posedge clk) begin mem_wr <= 1; mem_addr <= {base, o}; end
        mem_wdata <= v;
        @(posedge clk) mem_wr <= 0;
        #1;
    endtask
    task mr(input [11:0] o);
        @(posedge clk) begin mem_rd <= 1; mem_addr <= {base, o}; end
        @(posedge clk) mem_rd <= 0;
        #1 d = mem_rdata;
    endtask
    task send(input [2:0] k);
        @(posedge clk) begin go <= 1; kind <= k; end
        @(posedge clk) go <= 0;
    endtask
    task t_reset;
        msr_r;
        `CHK(q, {28'h0, 24'h0fee00, 12'h900})
        `CHK(window_base, 36'h0fee00000)
        `CHK(initial_id_out, 8'h5a)
    endtask
    task t_regs;
        reg [11:0] o [9];
        reg [31:0] e [9];
        o = '{12'h080, 12'h0d0, 12'h300, 12'h310, 12'h380, 12'h3e0,
            12'h0e0, 12'h0f0, 12'h020};
        e = '{0, 0, 0, 0, 0, 0, 32'hffffffff, 32'hff, 32'h5a000000};
        for (int i = 0; i < 9; i++) begin
            mr(o[i]);
            `CHK(d, e[i])
        end
        for (int i = 0; i < 6; i++) begin
            mr(12'h320 + i * 16);
            `CHK(d, 32'h00010000)
        end
    endtask
    task t_sw;
        mw(12'h0f0, 32'h1ff);
        @(posedge clk) #1 `CHK(unit_active, 1'b1)
        mw(12'h320, 0);
        mr(12'h320);
        `CHK(d, 32'h0)
        send(0);
        mw(12'h0f0, 32'hff);
        `CHK(accept_init, 1'b1)
        `CHK(unit_active, 1'b1)
        repeat (5) @(posedge clk);
        `CHK(unit_active, 1'b0)
        `CHK(fixed_accept, 1'b0)
        mw(12'h320, 0);
        mr(12'h320);
        `CHK(d, 32'h00010000)
        mw(12'h300, 32'h4500);
        `CHK(ipi_send, 1'b1)
        send(2);
        #1 `CHK(accept_smi, 1'b1)
        send(1);
        #1 `CHK(accept_nmi, 1'b1)
        send(3);
        #1 `CHK(accept_startup, 1'b0)
        send(4);
        #1 `CHK(accept_stop_clock, 1'b1)
        mw(12'h0f0, 32'h1ff);
        @(posedge clk) #1 `CHK(unit_active, 1'b1)
    endtask
    task t_move;
        base = 24'h0abcd;
        msr_w({28'h0, base, 12'h800});
        `CHK(window_base, 36'h0abcd000)
        mr(12'h0f0);
        `CHK(d, 32'h1ff)
        base = `LIEB_BASE_RESET;
        mr(12'h0f0);
        `CHK(d, 32'h0)
        msr_w({28'h0, base, 12'h800});
    endtask
    task t_global;
        mw(12'h080, 32'h20);
        msr_w({28'h0, base, 12'h000});
        `CHK(unit_present, 1'b0)
        msr_w({28'h0, base, 12'h800});
        `CHK(unit_present, 1'b1)
        mr(12'h080);
        `CHK(d, 32'h0)
    endtask
    task t_init;
        mw(12'h020, 32'h33000000);
        mw(12'h080, 32'h20);
        @(posedge clk) init_reset <= 1;
        @(posedge clk) init_reset <= 0;
        mr(12'h080);
        `CHK(d, 32'h0)
        mr(12'h020);
        `CHK(d, 32'h33000000)
        `CHK(initial_id_out, 8'h5a)
    endtask
    initial begin
        repeat (4) @(posedge clk);
        rstn <= 1;
        repeat (4) @(posedge clk);
        t_reset;
        t_regs;
        t_sw;
        t_move;
        t_global;
        t_init;
        test_done;
    end
    initial begin
        #100000;
        n_mismatch++;
        test_done;
    end
endmodule
